//--- hdl/slx_cfg.svh
// Register map, field positions, reset values and pulse codes for the lane crossbar block.
// Assumes an 8-bit register port with a 12-bit address, one lane word clock.
//
// Overview of operation
// R1: Lane 5 source select at map [5:3], resets 5
// R2: Lane 4 source select at map [2:0], resets 4
// R3: Lane 7 source select at second map [5:3]
// R4: Lane 6 source select at second map [2:0]
// R5: Select value x routes serial lane x
// R6: Read-only full flag per logical lane FIFO
// R7: Read-only empty flag per logical lane FIFO
// R8: Two-bit field sets sync low error duration
// R9: One duration setting drives both sync outputs
// R10: Multiframe with lane errors raises sync error
// R11: Host writes 0x01 to PHY config byte
// R12: Lanes 0 and 1 sources, reset 0, 1
// R13: Flags are live; reading never clears them
`ifndef SLX_CFG_SVH
`define SLX_CFG_SVH

// Register addresses
`define SLX_ADDR_MAP01 12'h308
`define SLX_ADDR_MAP45 12'h30A
`define SLX_ADDR_MAP67 12'h30B
`define SLX_ADDR_FULL 12'h30C
`define SLX_ADDR_EMPTY 12'h30D
`define SLX_ADDR_SYNC 12'h312
`define SLX_ADDR_PHY 12'h314

// Source select fields inside a crossbar register
`define SLX_SEL_LO_LSB 0
`define SLX_SEL_HI_LSB 3
`define SLX_SEL_W 3
`define SLX_MAP_MASK 8'h3F

// Error duration field inside the sync control register
`define SLX_DUR_LSB 4
`define SLX_DUR_W 2

// Reset values
`define SLX_RST_MAP01 8'h08
`define SLX_RST_MAP45 8'h2C
`define SLX_RST_MAP67 8'h3E
`define SLX_RST_SYNC 8'h10
`define SLX_RST_PHY 8'h00
`define SLX_RST_LANE2 3'h2
`define SLX_RST_LANE3 3'h3

// Error duration codes
`define SLX_DUR_HALF 2'h0
`define SLX_DUR_ONE 2'h1
`define SLX_DUR_TWO 2'h2

`endif

//--- hdl/slx_pkg.sv
// Types shared by the lane crossbar block.
// Assumes slx_cfg.svh for all numeric constants.
package slx_pkg;

  // Sync pulse generator phases
  typedef enum logic [1:0] {
    SLX_SYNC_IDLE,
    SLX_SYNC_LOW
  } slx_sync_st_t;

  // Sync pulse generator state
  typedef struct packed {
    slx_sync_st_t st;
    logic [1:0] cnt;
    logic half;
    logic err_seen;
  } slx_sync_state_t;

endpackage

//--- hdl/slx_sync_if.sv
// Bundle between the register side and one sync pulse generator.
// Assumes both ends run on the lane word clock.
`timescale 1ns/100ps
interface slx_sync_if;
  logic mf_end; // End of multiframe strobe
  logic lane_err; // Any decode error on the link this cycle
  logic link_req; // Link asks for resynchronisation
  logic [1:0] dur; // Error pulse length code
  logic sync_n; // Sync request, active low

  modport ctl (output mf_end, output lane_err, output link_req, output dur, input sync_n);
  modport gen (input mf_end, input lane_err, input link_req, input dur, output sync_n);
endinterface

//--- hdl/slx_sync_gen.sv
// Sync request generator for one link: error pulse at multiframe end.
// Assumes mf_end is a one-cycle strobe on the lane word clock.
`timescale 1ns/100ps
`include "slx_cfg.svh"
module slx_sync_gen
  import slx_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  slx_sync_if.gen sif
);

  slx_sync_state_t s_q; // Registered state
  slx_sync_state_t s_d; // Next state
  logic err_now; // Error seen this multiframe, this cycle included
  logic low_w; // Pulse is active

  // Next state
  always_comb begin
    s_d = s_q;
    // An error in the end cycle still belongs to the ending multiframe
    err_now = s_q.err_seen | sif.lane_err; // [R10]
    s_d.err_seen = err_now;
    unique case (s_q.st)
      SLX_SYNC_IDLE: begin
        if (sif.mf_end && err_now) begin // [R10]
          s_d.st = SLX_SYNC_LOW;
          s_d.half = (sif.dur == `SLX_DUR_HALF); // [R8]
          s_d.cnt = (sif.dur == `SLX_DUR_ONE || sif.dur == `SLX_DUR_HALF) ? 2'h1 : 2'h2; // [R8]
        end
      end
      SLX_SYNC_LOW: begin
        // Count down whole cycles of the pulse
        s_d.cnt = s_q.cnt - 2'h1;
        if (s_q.cnt == 2'h1) begin
          s_d.st = SLX_SYNC_IDLE;
          s_d.half = 1'b0;
        end
      end
    endcase
    if (sif.mf_end) begin
      s_d.err_seen = 1'b0;
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '{st: SLX_SYNC_IDLE, cnt: 2'h0, half: 1'b0, err_seen: 1'b0};
    end else begin
      s_q <= s_d;
    end
  end

  // Half-cycle pulse uses only the high phase of the first cycle
  assign low_w = (s_q.st == SLX_SYNC_LOW) && (!s_q.half || ref_clk_i); // [R8]
  assign sif.sync_n = !(low_w || sif.link_req);

endmodule

//--- hdl/slx_lane_fifo.sv
// Elastic FIFO for one logical lane with live full and empty flags.
// Assumes writer and reader share the lane word clock.
`timescale 1ns/100ps
`include "slx_cfg.svh"
module slx_lane_fifo #(
  parameter int W = 8,
  parameter int DEPTH = 8
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic wr_i,
  input wire logic [W-1:0] wdata_i,
  input wire logic rd_i,
  output logic [W-1:0] rdata_o,
  output logic full_o,
  output logic empty_o
);
  localparam int AW = $clog2(DEPTH);

  // Refuse depths the pointer wrap cannot serve
  if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
    $error("slx_lane_fifo: DEPTH must be a power of two, at least 2");
  end

  typedef struct packed {
    logic [AW-1:0] wp;
    logic [AW-1:0] rp;
    logic [AW:0] cnt;
    logic [W-1:0] rdata;
  } slx_fifo_state_t;

  slx_fifo_state_t s_q; // Registered state
  slx_fifo_state_t s_d; // Next state
  logic [W-1:0] mem [DEPTH]; // Lane storage
  logic push; // Accepted write
  logic pop; // Accepted read

  assign full_o = (s_q.cnt == (AW+1)'(DEPTH)); // [R6] [R13]
  assign empty_o = (s_q.cnt == '0); // [R7] [R13]
  assign push = wr_i && !full_o;
  assign pop = rd_i && !empty_o;
  assign rdata_o = s_q.rdata;

  // Pointer and count update
  always_comb begin
    s_d = s_q;
    if (push) begin
      s_d.wp = s_q.wp + 1'b1;
    end
    if (pop) begin
      s_d.rp = s_q.rp + 1'b1;
      s_d.rdata = mem[s_q.rp];
    end
    s_d.cnt = s_q.cnt + (AW+1)'(push) - (AW+1)'(pop);
  end

  // State register
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // Storage has no reset
  always_ff @(posedge ref_clk_i) begin
    if (push) begin
      mem[s_q.wp] <= wdata_i;
    end
  end

endmodule

//--- hdl/slx_top.sv
// Receive lane crossbar with lane FIFOs, FIFO status and sync request timing.
// Assumes lane words, valids and decode errors come from PHY logic on ref_clk_i,
// and that the register port is driven by a serial port engine on the same clock.
`timescale 1ns/100ps
`include "slx_cfg.svh"
module slx_top
  import slx_pkg::*;
#(
  parameter int NL = 8, // Physical and logical lanes
  parameter int W = 8, // Lane word width
  parameter int DEPTH = 8 // FIFO depth per lane
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  output logic [7:0] reg_rdata_o,
  input wire logic [NL-1:0][W-1:0] serial_lane_in_i,
  input wire logic [NL-1:0] serial_lane_vld_i,
  input wire logic [NL-1:0] disp_err_i,
  input wire logic [NL-1:0] nit_err_i,
  input wire logic [NL-1:0] ctrl_err_i,
  input wire logic [NL-1:0] lane_rd_i,
  output logic [NL-1:0][W-1:0] lane_data_o,
  input wire logic [NL-1:0] link0_lanes_i,
  input wire logic [NL-1:0] link1_lanes_i,
  input wire logic [1:0] mf_end_i,
  input wire logic [1:0] link_sync_req_i,
  output logic [1:0] sync_request_out_n_o,
  output logic [7:0] phy_config_value_o
);

  // The select fields and status bytes are three and eight bits wide
  if (NL != 8) begin : g_bad_lanes
    $error("slx_top: NL must be 8");
  end
  if (W < 1) begin : g_bad_width
    $error("slx_top: W must be positive");
  end

  typedef struct packed {
    logic [7:0] map01; // Lanes 0 and 1 sources
    logic [7:0] map45; // Lanes 4 and 5 sources
    logic [7:0] map67; // Lanes 6 and 7 sources
    logic [7:0] sync_ctrl; // Error duration and spare bits
    logic [7:0] phy_cfg; // PHY configuration byte
    logic [7:0] rdata; // Register read data
    logic [NL-1:0][W-1:0] xdata; // Crossbar output words
    logic [NL-1:0] xvld; // Crossbar output valids
    logic [NL-1:0] xerr; // Crossbar output decode errors
  } slx_top_state_t;

  slx_top_state_t s_q; // Registered state
  slx_top_state_t s_d; // Next state
  logic [NL-1:0][2:0] sel; // Source lane per logical lane
  logic [NL-1:0] phys_err; // Any decode error per physical lane
  logic [NL-1:0] fifo_full; // Live full flags
  logic [NL-1:0] fifo_empty; // Live empty flags
  logic [NL-1:0][W-1:0] fifo_data; // FIFO read words

  // Low select field of a crossbar register
  function automatic logic [2:0] sel_lo(input logic [7:0] r);
    sel_lo = r[`SLX_SEL_LO_LSB +: `SLX_SEL_W];
  endfunction

  // High select field of a crossbar register
  function automatic logic [2:0] sel_hi(input logic [7:0] r);
    sel_hi = r[`SLX_SEL_HI_LSB +: `SLX_SEL_W];
  endfunction

  // Source select per logical lane
  always_comb begin
    sel[0] = sel_lo(s_q.map01); // [R12]
    sel[1] = sel_hi(s_q.map01); // [R12]
    // Lanes 2 and 3 sit on their power-up sources
    sel[2] = `SLX_RST_LANE2;
    sel[3] = `SLX_RST_LANE3;
    sel[4] = sel_lo(s_q.map45); // [R2]
    sel[5] = sel_hi(s_q.map45); // [R1]
    sel[6] = sel_lo(s_q.map67); // [R4]
    sel[7] = sel_hi(s_q.map67); // [R3]
  end

  // Merge the three decode error kinds per physical lane
  assign phys_err = disp_err_i | nit_err_i | ctrl_err_i; // [R10]

  // Next state: register writes, reads and crossbar
  always_comb begin
    s_d = s_q;
    // Register writes; reserved crossbar bits stay zero
    if (reg_wr_i) begin
      unique case (reg_addr_i)
        `SLX_ADDR_MAP01: begin
          s_d.map01 = reg_wdata_i & `SLX_MAP_MASK; // [R12]
        end
        `SLX_ADDR_MAP45: begin
          s_d.map45 = reg_wdata_i & `SLX_MAP_MASK; // [R1] [R2]
        end
        `SLX_ADDR_MAP67: begin
          s_d.map67 = reg_wdata_i & `SLX_MAP_MASK; // [R3] [R4]
        end
        `SLX_ADDR_SYNC: begin
          s_d.sync_ctrl = reg_wdata_i; // [R8]
        end
        `SLX_ADDR_PHY: begin
          s_d.phy_cfg = reg_wdata_i; // [R11]
        end
        default: begin
          // Writes to status or unmapped addresses are dropped
        end
      endcase
    end
    // Register reads; status reads leave the flags untouched
    unique case (reg_addr_i)
      `SLX_ADDR_MAP01: begin
        s_d.rdata = s_q.map01;
      end
      `SLX_ADDR_MAP45: begin
        s_d.rdata = s_q.map45;
      end
      `SLX_ADDR_MAP67: begin
        s_d.rdata = s_q.map67;
      end
      `SLX_ADDR_FULL: begin
        s_d.rdata = fifo_full; // [R6] [R13]
      end
      `SLX_ADDR_EMPTY: begin
        s_d.rdata = fifo_empty; // [R7] [R13]
      end
      `SLX_ADDR_SYNC: begin
        s_d.rdata = s_q.sync_ctrl;
      end
      `SLX_ADDR_PHY: begin
        s_d.rdata = s_q.phy_cfg;
      end
      default: begin
        // Unmapped addresses read zero
        s_d.rdata = 8'h00;
      end
    endcase
    // Crossbar: logical lane i takes physical lane sel[i]
    for (int i = 0; i < NL; i++) begin
      s_d.xdata[i] = serial_lane_in_i[sel[i]]; // [R5]
      s_d.xvld[i] = serial_lane_vld_i[sel[i]]; // [R5]
      s_d.xerr[i] = phys_err[sel[i]]; // [R5]
    end
  end

  // State register
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      s_q.map01 <= `SLX_RST_MAP01; // [R12]
      s_q.map45 <= `SLX_RST_MAP45; // [R1] [R2]
      s_q.map67 <= `SLX_RST_MAP67; // [R3] [R4]
      s_q.sync_ctrl <= `SLX_RST_SYNC;
      s_q.phy_cfg <= `SLX_RST_PHY; // [R11]
      s_q.rdata <= 8'h00;
      s_q.xdata <= '0;
      s_q.xvld <= '0;
      s_q.xerr <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  // One FIFO per logical lane
  for (genvar g = 0; g < NL; g++) begin : g_lane
    slx_lane_fifo #(
      .W(W),
      .DEPTH(DEPTH)
    ) u_fifo (
      .ref_clk_i(ref_clk_i),
      .sys_rst_i(sys_rst_i),
      .wr_i(s_q.xvld[g]),
      .wdata_i(s_q.xdata[g]),
      .rd_i(lane_rd_i[g]),
      .rdata_o(fifo_data[g]),
      .full_o(fifo_full[g]), // [R6]
      .empty_o(fifo_empty[g]) // [R7]
    );
  end

  // Two links, each with its own sync request generator
  slx_sync_if sif0 ();
  slx_sync_if sif1 ();

  // Link 0 bundle; both links read the same duration field
  assign sif0.mf_end = mf_end_i[0];
  assign sif0.lane_err = |(s_q.xerr & link0_lanes_i); // [R10]
  assign sif0.link_req = link_sync_req_i[0];
  assign sif0.dur = s_q.sync_ctrl[`SLX_DUR_LSB +: `SLX_DUR_W]; // [R8] [R9]

  // Link 1 bundle
  assign sif1.mf_end = mf_end_i[1];
  assign sif1.lane_err = |(s_q.xerr & link1_lanes_i); // [R10]
  assign sif1.link_req = link_sync_req_i[1];
  assign sif1.dur = s_q.sync_ctrl[`SLX_DUR_LSB +: `SLX_DUR_W]; // [R9]

  // Link 0 generator
  slx_sync_gen u_sync0 (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .sif(sif0.gen)
  );

  // Link 1 generator
  slx_sync_gen u_sync1 (
    .ref_clk_i(ref_clk_i),
    .sys_rst_i(sys_rst_i),
    .sif(sif1.gen)
  );

  // Outputs
  assign sync_request_out_n_o = {sif1.sync_n, sif0.sync_n};
  assign lane_data_o = fifo_data;
  assign reg_rdata_o = s_q.rdata;
  assign phy_config_value_o = s_q.phy_cfg;

endmodule

//--- tb/slx_top_assertions.sv
// Concurrent checks on the register port and sync outputs of the lane crossbar block.
// Assumes it is bound to slx_top and sees only that module's ports.
`timescale 1ns/100ps
`include "slx_cfg.svh"
module slx_top_chk #(
  parameter int NL = 8 // Lane count
) (
  input wire logic ref_clk_i,
  input wire logic sys_rst_i,
  input wire logic [11:0] reg_addr_i,
  input wire logic reg_wr_i,
  input wire logic [7:0] reg_wdata_i,
  input wire logic [7:0] reg_rdata_o,
  input wire logic [NL-1:0] serial_lane_vld_i,
  input wire logic [NL-1:0] lane_rd_i,
  input wire logic [1:0] mf_end_i,
  input wire logic [1:0] link_sync_req_i,
  input wire logic [1:0] sync_request_out_n_o,
  input wire logic [7:0] phy_config_value_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (sys_rst_i);
  logic [1:0] dur_q; // Shadow of the pulse length code
  logic [2:0] quiet_q; // Idle cycles spent reading the empty flags

  // Track the length code and count reads with no lane traffic
  always_ff @(posedge ref_clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      dur_q <= `SLX_DUR_ONE;
      quiet_q <= 3'h0;
    end else begin
      if (reg_wr_i && reg_addr_i == `SLX_ADDR_SYNC) dur_q <= reg_wdata_i[5:4];
      if (reg_addr_i == `SLX_ADDR_EMPTY && !reg_wr_i && !(|serial_lane_vld_i) && !(|lane_rd_i))
        quiet_q <= (quiet_q == 3'h7) ? quiet_q : quiet_q + 3'h1;
      else
        quiet_q <= 3'h0;
    end
  end

  // Write, then hold the same address with no write
  sequence s_wr_rd(a);
    reg_wr_i && reg_addr_i == a ##1 reg_addr_i == a && !reg_wr_i;
  endsequence
  property p_map45;
    s_wr_rd(`SLX_ADDR_MAP45) |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h3F);
  endproperty
  a_map45: assert property (p_map45) else $error("lane 4/5 map readback wrong");
  property p_map67;
    s_wr_rd(`SLX_ADDR_MAP67) |=> reg_rdata_o == ($past(reg_wdata_i, 2) & 8'h3F);
  endproperty
  a_map67: assert property (p_map67) else $error("lane 6/7 map readback wrong");
  property p_syncctl;
    s_wr_rd(`SLX_ADDR_SYNC) |=> reg_rdata_o == $past(reg_wdata_i, 2);
  endproperty
  a_syncctl: assert property (p_syncctl) else $error("sync control readback wrong");
  property p_phy;
    reg_wr_i && reg_addr_i == `SLX_ADDR_PHY |=> phy_config_value_o == $past(reg_wdata_i);
  endproperty
  a_phy: assert property (p_phy) else $error("phy byte not stored");
  property p_sync_one;
    $fell(sync_request_out_n_o[0]) && dur_q == 2'h1 && !link_sync_req_i[0] |=> sync_request_out_n_o[0];
  endproperty
  a_sync_one: assert property (p_sync_one) else $error("one cycle pulse wrong");
  property p_sync_two;
    $fell(sync_request_out_n_o[1]) && dur_q >= 2'h2 && !link_sync_req_i[1]
      |=> !sync_request_out_n_o[1] ##1 sync_request_out_n_o[1];
  endproperty
  a_sync_two: assert property (p_sync_two) else $error("two cycle pulse wrong");
  property p_sync_cause;
    $fell(sync_request_out_n_o[0]) && !link_sync_req_i[0] |-> $past(mf_end_i[0]);
  endproperty
  a_sync_cause: assert property (p_sync_cause) else $error("pulse without multiframe end");
  property p_quiet;
    quiet_q >= 3'h4 |-> $stable(reg_rdata_o);
  endproperty
  a_quiet: assert property (p_quiet) else $error("flag read changed by reading");

  c_two: cover property ($fell(sync_request_out_n_o[1]) && dur_q == 2'h2);
  c_phy: cover property (reg_wr_i && reg_addr_i == `SLX_ADDR_PHY);
  c_quiet: cover property (quiet_q == 3'h7);
endmodule

bind slx_top slx_top_chk #(.NL(NL)) chk_u (.ref_clk_i, .sys_rst_i, .reg_addr_i, .reg_wr_i,
  .reg_wdata_i, .reg_rdata_o, .serial_lane_vld_i, .lane_rd_i, .mf_end_i, .link_sync_req_i,
  .sync_request_out_n_o, .phy_config_value_o);

//--- tb/slx_tx_model.sv
// Transmitter model driving the serial lanes, decode errors and multiframe ends.
// Assumes its tasks are called just after a rising edge of ref_clk_i.
`timescale 1ns/100ps
module slx_tx_model #(
  parameter int NL = 8, // Lane count
  parameter int W = 8 // Word width
) (
  input wire logic ref_clk_i,
  output logic [NL-1:0][W-1:0] lane_o, // Word per physical lane
  output logic [NL-1:0] vld_o, // Word valid per lane
  output logic [NL-1:0] disp_o, // Disparity error
  output logic [NL-1:0] nit_o, // Not-in-table error
  output logic [NL-1:0] ctrl_o, // Unexpected control character
  output logic [1:0] mf_end_o // Multiframe end per link
);
  // Idle lanes show the inverse of the last word so stale data never passes as valid
  task automatic idle();
    for (int p = 0; p < NL; p++) lane_o[p] = ~lane_o[p];
    vld_o = '0;
  endtask

  // Quiet link at time zero
  initial begin
    lane_o = '0;
    vld_o = '0;
    disp_o = '0;
    nit_o = '0;
    ctrl_o = '0;
    mf_end_o = 2'h0;
  end

  // Sends n valid words on every lane: 0xA0 plus the lane number
  task automatic send(input int n);
    for (int p = 0; p < NL; p++) lane_o[p] = W'(8'hA0 + p);
    vld_o = '1;
    repeat (n) @(posedge ref_clk_i);
    #1;
    idle();
  endtask

  // One error of kind k on lane 0 (3 is none), then a multiframe end on both links
  task automatic err_frame(input int k);
    disp_o[0] = (k == 0);
    nit_o[0] = (k == 1);
    ctrl_o[0] = (k == 2);
    @(posedge ref_clk_i);
    #1;
    disp_o = '0;
    nit_o = '0;
    ctrl_o = '0;
    mf_end_o = 2'h3;
    @(posedge ref_clk_i);
    #1;
    mf_end_o = 2'h0;
  endtask
endmodule

//--- tb/slx_top_test.sv
// Bench for the lane crossbar block: registers, lane routing, FIFO flags, sync pulses.
// Assumes the transmitter model owns the lanes and the bench owns the register port.
`timescale 1ns/100ps
`define CHK(a, e) begin checked++; if ((a) !== (e)) begin bad_count++; $display("[FAIL] %0t: got %h, expected %h", $time, (a), (e)); end end
module slx_top_test;
  localparam int NL = 8;
  localparam int W = 8;
  localparam int DEPTH = 8;
  // Low samples per pulse, two per cycle: half cycle 1, one cycle 2, two cycles 4, none 0
  localparam int EXP_LO [5] = '{1, 2, 4, 4, 0};
  logic ref_clk_i = 1'b0;
  logic sys_rst_i = 1'b1;
  logic [11:0] reg_addr_i = 12'h000;
  logic reg_wr_i = 1'b0;
  logic [7:0] reg_wdata_i = 8'h00;
  logic [7:0] reg_rdata_o;
  logic [NL-1:0][W-1:0] lanes;
  logic [NL-1:0][W-1:0] lane_data_o;
  logic [NL-1:0] vld, disp, nit, ctrl;
  logic [NL-1:0] lane_rd_i = '0;
  logic [1:0] mf_end, sync_n;
  logic [7:0] phy_o;
  int bad_count = 0;
  int checked = 0;
  int lo [2];

  // 125 MHz lane word clock
  always #4 ref_clk_i = ~ref_clk_i;

  slx_tx_model #(.NL(NL), .W(W)) tx_u (.ref_clk_i(ref_clk_i), .lane_o(lanes), .vld_o(vld),
    .disp_o(disp), .nit_o(nit), .ctrl_o(ctrl), .mf_end_o(mf_end));

  // Link 0 owns lanes 0-3, link 1 lanes 4-7
  slx_top #(.NL(NL), .W(W), .DEPTH(DEPTH)) dut_u (.ref_clk_i(ref_clk_i), .sys_rst_i(sys_rst_i),
    .reg_addr_i(reg_addr_i), .reg_wr_i(reg_wr_i), .reg_wdata_i(reg_wdata_i),
    .reg_rdata_o(reg_rdata_o), .serial_lane_in_i(lanes), .serial_lane_vld_i(vld),
    .disp_err_i(disp), .nit_err_i(nit), .ctrl_err_i(ctrl), .lane_rd_i(lane_rd_i),
    .lane_data_o(lane_data_o), .link0_lanes_i(8'h0F), .link1_lanes_i(8'hF0), .mf_end_i(mf_end),
    .link_sync_req_i(2'h0), .sync_request_out_n_o(sync_n), .phy_config_value_o(phy_o));

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk_i);
    #1;
  endtask
  // Write, then one idle cycle so the strobe is never re-raised in the same step
  task automatic wr(input logic [11:0] a, input logic [7:0] d);
    reg_addr_i = a;
    reg_wr_i = 1'b1;
    reg_wdata_i = d;
    tick(1);
    reg_wr_i = 1'b0;
    tick(1);
  endtask
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    reg_addr_i = a;
    tick(1);
    `CHK(reg_rdata_o, e)
  endtask
  // Pops the lanes in mask m for n cycles
  task automatic pop(input logic [NL-1:0] m, input int n);
    lane_rd_i = m;
    tick(n);
    lane_rd_i = '0;
  endtask
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // Watchdog: the tests need about 120 cycles
  initial begin
    repeat (3000) @(posedge ref_clk_i);
    bad_count++;
    $display("[FAIL] %0t: watchdog expired", $time);
    final_report();
  end

  // Main sequence
  initial begin
    repeat (8) @(posedge ref_clk_i);
    #1;
    sys_rst_i = 1'b0;
    rd(12'h308, 8'h08);
    rd(12'h30A, 8'h2C);
    rd(12'h30B, 8'h3E);
    rd(12'h30C, 8'h00);
    rd(12'h30D, 8'hFF);
    rd(12'h312, 8'h10);
    rd(12'h314, 8'h00);
    $display("Test reset values done");
    wr(12'h30A, 8'hFF);
    rd(12'h30A, 8'h3F);
    wr(12'h30B, 8'hC0);
    rd(12'h30B, 8'h00);
    wr(12'h312, 8'hA5);
    rd(12'h312, 8'hA5);
    wr(12'h314, 8'h01);
    rd(12'h314, 8'h01);
    `CHK(phy_o, 8'h01)
    wr(12'h30C, 8'h55);
    rd(12'h30C, 8'h00);
    wr(12'h30D, 8'h00);
    rd(12'h30D, 8'hFF);
    rd(12'h300, 8'h00);
    $display("Test register access done");
    // Lane 4 from 7, lane 5 from 0, lane 6 from 3, lane 7 from 6
    wr(12'h30A, 8'h07);
    wr(12'h30B, 8'h33);
    tx_u.send(1);
    tick(2);
    rd(12'h30D, 8'h00);
    pop('1, 1);
    `CHK(lane_data_o[0], 8'hA0)
    `CHK(lane_data_o[1], 8'hA1)
    `CHK(lane_data_o[2], 8'hA2)
    `CHK(lane_data_o[3], 8'hA3)
    `CHK(lane_data_o[4], 8'hA7)
    `CHK(lane_data_o[5], 8'hA0)
    `CHK(lane_data_o[6], 8'hA3)
    `CHK(lane_data_o[7], 8'hA6)
    tick(1);
    rd(12'h30D, 8'hFF);
    tick(5);
    rd(12'h30D, 8'hFF);
    $display("Test lane routing done");
    tx_u.send(DEPTH + 2);
    tick(2);
    rd(12'h30C, 8'hFF);
    rd(12'h30C, 8'hFF);
    rd(12'h30D, 8'h00);
    pop('1, DEPTH);
    tick(2);
    rd(12'h30D, 8'hFF);
    rd(12'h30C, 8'h00);
    $display("Test fifo flags done");
    // Lane 0 feeds lanes 0 and 5, so one error reaches both links
    for (int i = 0; i < 5; i++) begin
      wr(12'h312, 8'((i % 4) << 4));
      tx_u.err_frame(i < 4 ? i % 3 : 3);
      lo = '{0, 0};
      repeat (4) begin
        #1;
        foreach (lo[l]) lo[l] += int'(sync_n[l] === 1'b0);
        #4;
        foreach (lo[l]) lo[l] += int'(sync_n[l] === 1'b0);
        #3;
      end
      `CHK(lo[0], EXP_LO[i])
      `CHK(lo[1], EXP_LO[i])
    end
    $display("Test sync pulses done");
    final_report();
  end
endmodule
